// file: lics_pkg.sv
/*
 * lics_pkg: constants and carrier types for the charge sequencer.
 * Assumes a single 250 MHz clock; short times are converted to cycles here, long ones to milliseconds.
 */
package lics_pkg;

	localparam int unsigned CLK_HZ = 250_000_000;

	// times as specified, in their own units
	localparam int unsigned OVP_DGL_MS     = 30;
	localparam int unsigned SLEEP_DGL_US   = 64;
	localparam int unsigned WAKE_MS        = 10;
	localparam int unsigned OCP_REC_MS     = 250;
	localparam int unsigned OCP_RETRY_S    = 2;
	localparam int unsigned UVLO_DGL_US    = 60;
	localparam int unsigned TS_ON_MS       = 4;
	localparam int unsigned TS_OFF_MS      = 196;
	localparam int unsigned WDOG_SHORT_S   = 40;
	localparam int unsigned WDOG_LONG_S    = 160;
	localparam int unsigned BUS_IDLE_MS    = 500;
	localparam int unsigned PRECHG_PCT     = 25;
	localparam int unsigned PCT_FULL       = 100;

	// millisecond tick divider; long timers count ticks
	localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;
	localparam int unsigned SLEEP_DGL_CYC  = (CLK_HZ / 1_000_000) * SLEEP_DGL_US;
	localparam int unsigned UVLO_DGL_CYC   = (CLK_HZ / 1_000_000) * UVLO_DGL_US;
	localparam int unsigned OCP_RETRY_MS   = OCP_RETRY_S * 1000;
	localparam int unsigned WDOG_SHORT_MS  = WDOG_SHORT_S * 1000;
	localparam int unsigned WDOG_LONG_MS   = WDOG_LONG_S * 1000;

	// regulation voltage clamp in millivolts
	localparam logic [12:0] VREG_MAX_MV    = 13'd4650;

	// register map (byte offsets)
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_VREG       = 8'h04;
	localparam logic [7:0] ADDR_TIMER      = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0C;
	localparam logic [7:0] ADDR_VREG_EFF   = 8'h10;

	// ctrl field positions
	localparam int unsigned CTRL_CHG_DIS   = 0;
	localparam int unsigned CTRL_TERM_LO   = 1;
	localparam int unsigned CTRL_WDOG_LO   = 3;
	localparam int unsigned CTRL_WD_KICK   = 5;

	// reset values
	localparam logic [1:0]  TERM_RST       = 2'h1;
	localparam logic [1:0]  WDOG_RST       = 2'h0;
	localparam logic [12:0] VREG_RST       = 13'd4200;
	localparam logic [19:0] TMR_RST_MIN    = 20'd180;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_TRICKLE = 3'b001,
		ST_PRECHG  = 3'b010,
		ST_FAST    = 3'b011,
		ST_DONE    = 3'b100,
		ST_FAULT   = 3'b101,
		ST_INHIBIT = 3'b110
	} lics_state_t;

	typedef enum logic [1:0] {
		TERM_OFF = 2'b00,
		TERM_5   = 2'b01,
		TERM_10  = 2'b10,
		TERM_20  = 2'b11
	} lics_term_t;

	// analog comparator and loop status, from the battery/input side
	typedef struct packed {
		logic in_valid;        // input valid: above limit, above bat+sleep, below ovp
		logic in_ovp;          // above input_overvoltage_level
		logic in_sleep;        // vin below bat + sleep margin
		logic in_present;      // input above uvlo
		logic bat_short;       // below battery_short_threshold
		logic bat_low;         // below fast_charge_entry_voltage
		logic bat_uvlo;        // below battery_undervoltage_level
		logic bat_rech;        // below reg voltage minus recharge_margin
		logic at_term;         // charge current at or below termination_current
		logic cv_loop;         // cv loop dominant
		logic vin_limit;       // input_voltage_power_limit active
		logic pp_limit;        // power_path_limit_loop active
		logic therm_reg;       // thermal regulation active
		logic ts_ok;           // temp_sense_button_pin in range
		logic ts_fault;        // temp sense reduced-current zone
		logic bat_ocp;         // battery_overcurrent_protect trip
		logic sys_need;        // sys below supplement threshold
	} lics_sense_t;

	typedef struct packed {
		logic       battery_switch;
		logic       supplement;
		logic [1:0] current_sel;   // 0 none,1 trickle,2 precharge,3 fast
		logic       reduce_cur;
		logic [1:0] term_sel;
		logic       ts_bias;
		logic       sleep;
		logic       in_ovp_act;
		logic       wake_ok;
		logic       ocp_hold;
	} lics_ctl_t;

endpackage

// file: lics_sequencer.sv
/*
 * lics_sequencer: charge sequencer, protection deglitch timers, temp-sense
 * duty cycling, watchdog and bus-inactivity resets, with a register port.
 * Assumes comparator inputs are synchronous to i_clock and already clean.
 */
// Behaviour
// - charge starts only with valid input, inhibit, temp
// - inhibit with valid input holds switch off
// - supplement works regardless of inhibit bit
// - below short threshold charge trickle, timed
// - pre-charge budget quarter fast timer, else stop
// - between thresholds charge at pre-charge current
// - at entry threshold switch to fast current
// - fast charge reduced by fault or limiting loops
// - termination current reached sets charge done
// - regulation voltage clamped at 4.65 V
// - termination field selects off,5,10,20 percent
// - termination in cv opens battery switch
// - no termination while limiting loops active
// - recharge below margin restarts, resets timers
// - overvoltage recovery deglitched 30 ms
// - sleep entry requires 64 us persistence
// - ship exit requires input 10 ms
// - overcurrent recovery 250 ms, retry window 2 s
// - undervoltage disconnect after 60 us
// - battery-only temp bias 4 ms on, 196 off
// - watchdog selectable 40 s, 160 s, off
// - bus inactivity 500 ms resets interface
`timescale 1ns/1ps
`default_nettype none
module lics_sequencer #(
	parameter int unsigned MS_CYC = lics_pkg::MS_CYCLES
) (
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	input  wire lics_pkg::lics_sense_t i_sense,
	input  wire logic               i_ship,
	input  wire logic               i_bus_activity,
	input  wire logic [7:0]         i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic [31:0]             o_rdata,
	output var lics_pkg::lics_ctl_t o_ctl,
	output logic                    o_charge_done,
	output logic                    o_timer_fault,
	output logic                    o_wdog_reset,
	output logic                    o_bus_reset
);

	// 32 bits hold the fast timer in ms only up to 71582 minutes; larger timer values wrap
	function automatic logic [31:0] min_to_ms(input logic [19:0] m);
		min_to_ms = {12'h000, m} * 32'd60000;
	endfunction

	lics_pkg::lics_state_t state_reg;
	lics_pkg::lics_state_t state_next;

	logic        chg_dis_reg;
	logic [1:0]  term_reg;
	logic [1:0]  wdog_sel_reg;
	logic [12:0] vreg_reg;
	logic [19:0] tmr_min_reg;
	logic [31:0] rdata_reg;
	logic [12:0] vreg_eff;
	logic        kick;

	logic [31:0] div_reg;
	logic        tick;
	logic [31:0] safety_reg;
	logic [31:0] safety_lim;
	logic [31:0] pre_lim;
	logic        safety_clr;

	logic [31:0] ovp_ms_reg;
	logic        ovp_act_reg;
	logic [31:0] slp_cyc_reg;
	logic        sleep_reg;
	logic [31:0] wake_ms_reg;
	logic        wake_reg;
	logic [31:0] ocp_ms_reg;
	logic [31:0] retry_ms_reg;
	logic        ocp_hold_reg;
	logic [31:0] uv_cyc_reg;
	logic        uv_off_reg;
	logic [31:0] ts_ms_reg;
	logic        ts_bias_reg;
	logic [31:0] wd_ms_reg;
	logic        wd_rst_reg;
	logic [31:0] idle_ms_reg;
	logic        bus_rst_reg;
	logic        done_reg;
	logic        fault_reg;
	logic        term_hit;

	// millisecond enable pulse; all long timers step on it
	always_ff @(posedge i_clock) begin
		if (i_rst || div_reg == MS_CYC - 1) begin
			div_reg <= 32'h0;
		end else begin
			div_reg <= div_reg + 32'h1;
		end
	end
	assign tick = (div_reg == MS_CYC - 1);

	// effective regulation voltage, clamped at the top
	assign vreg_eff = (vreg_reg > lics_pkg::VREG_MAX_MV) ? lics_pkg::VREG_MAX_MV : vreg_reg;

	// register writes
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			chg_dis_reg  <= 1'b0;
			term_reg     <= lics_pkg::TERM_RST;
			wdog_sel_reg <= lics_pkg::WDOG_RST;
			vreg_reg     <= lics_pkg::VREG_RST;
			tmr_min_reg  <= lics_pkg::TMR_RST_MIN;
		end else if (i_wr) begin
			unique case (i_addr)
				lics_pkg::ADDR_CTRL: begin
					chg_dis_reg  <= i_wdata[lics_pkg::CTRL_CHG_DIS];
					term_reg     <= i_wdata[lics_pkg::CTRL_TERM_LO +: 2];
					wdog_sel_reg <= i_wdata[lics_pkg::CTRL_WDOG_LO +: 2];
				end
				lics_pkg::ADDR_VREG:  vreg_reg    <= i_wdata[12:0];
				lics_pkg::ADDR_TIMER: tmr_min_reg <= i_wdata[19:0];
				default: ;
			endcase
		end
	end
	assign kick = i_wr && i_addr == lics_pkg::ADDR_CTRL && i_wdata[lics_pkg::CTRL_WD_KICK];

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clock) begin
		if (i_rst || !i_rd) begin
			rdata_reg <= 32'h0;
		end else begin
			unique case (i_addr)
				lics_pkg::ADDR_CTRL:     rdata_reg <= {26'h0, 1'b0, wdog_sel_reg, term_reg, chg_dis_reg};
				lics_pkg::ADDR_VREG:     rdata_reg <= {19'h0, vreg_reg};
				lics_pkg::ADDR_TIMER:    rdata_reg <= {12'h0, tmr_min_reg};
				lics_pkg::ADDR_STATUS:   rdata_reg <= {22'h0, uv_off_reg, ocp_hold_reg, sleep_reg, ovp_act_reg,
					fault_reg, done_reg, 1'b0, state_reg};
				lics_pkg::ADDR_VREG_EFF: rdata_reg <= {19'h0, vreg_eff};
				default:                 rdata_reg <= 32'h0;
			endcase
		end
	end
	assign o_rdata = rdata_reg;

	// limits for the shared pre-charge budget and the fast timer
	assign safety_lim = min_to_ms(tmr_min_reg);
	assign pre_lim    = (safety_lim / lics_pkg::PCT_FULL) * lics_pkg::PRECHG_PCT;
	// termination only in pure cv with no limiting loop, and field not off
	assign term_hit = i_sense.at_term && i_sense.cv_loop && term_reg != lics_pkg::TERM_OFF
		&& !i_sense.vin_limit && !i_sense.pp_limit && !i_sense.therm_reg;

	// charge phase selection
	always_comb begin
		state_next = state_reg;
		safety_clr = 1'b0;
		unique case (state_reg)
			lics_pkg::ST_IDLE, lics_pkg::ST_INHIBIT: begin
				if (i_sense.in_valid && !ovp_act_reg && !sleep_reg) begin
					if (chg_dis_reg || !i_sense.ts_ok) begin
						state_next = lics_pkg::ST_INHIBIT;
					end else begin
						safety_clr = 1'b1;
						state_next = i_sense.bat_short ? lics_pkg::ST_TRICKLE
							: (i_sense.bat_low ? lics_pkg::ST_PRECHG : lics_pkg::ST_FAST);
					end
				end else begin
					state_next = lics_pkg::ST_IDLE;
				end
			end
			lics_pkg::ST_TRICKLE, lics_pkg::ST_PRECHG: begin
				if (safety_reg >= pre_lim) begin
					state_next = lics_pkg::ST_FAULT;
				end else if (i_sense.bat_short) begin
					state_next = lics_pkg::ST_TRICKLE;
				end else if (i_sense.bat_low) begin
					state_next = lics_pkg::ST_PRECHG;
				end else begin
					state_next = lics_pkg::ST_FAST;
				end
			end
			lics_pkg::ST_FAST: begin
				if (term_hit) begin
					state_next = lics_pkg::ST_DONE;
				end else if (safety_reg >= safety_lim) begin
					state_next = lics_pkg::ST_FAULT;
				end
			end
			lics_pkg::ST_DONE: begin
				if (i_sense.bat_rech) begin
					safety_clr = 1'b1;
					state_next = lics_pkg::ST_IDLE;
				end
			end
			lics_pkg::ST_FAULT: ;
			default: state_next = lics_pkg::ST_IDLE;
		endcase
		// losing input, inhibit, an overvoltage hold or sleep aborts any phase
		if (state_reg != lics_pkg::ST_IDLE && state_reg != lics_pkg::ST_INHIBIT
			&& (!i_sense.in_valid || ovp_act_reg || sleep_reg || chg_dis_reg)) begin
			state_next = lics_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_reg <= lics_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// safety timer; trickle time counts against the same budget
	always_ff @(posedge i_clock) begin
		if (i_rst || safety_clr) begin
			safety_reg <= 32'h0;
		end else if (tick && (state_reg == lics_pkg::ST_TRICKLE || state_reg == lics_pkg::ST_PRECHG
			|| state_reg == lics_pkg::ST_FAST)) begin
			safety_reg <= safety_reg + 32'h1;
		end
	end

	// done and fault flags hold until a new cycle starts
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			done_reg  <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			if (state_next == lics_pkg::ST_DONE) begin
				done_reg <= 1'b1;
			end else if (safety_clr) begin
				done_reg <= 1'b0;
			end
			if (state_next == lics_pkg::ST_FAULT) begin
				fault_reg <= 1'b1;
			end else if (safety_clr) begin
				fault_reg <= 1'b0;
			end
		end
	end

	// overvoltage: set at once, released after 30 ms of clean input
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ovp_act_reg <= 1'b0;
			ovp_ms_reg  <= 32'h0;
		end else if (i_sense.in_ovp) begin
			ovp_act_reg <= 1'b1;
			ovp_ms_reg  <= 32'h0;
		end else if (ovp_act_reg && tick) begin
			if (ovp_ms_reg == lics_pkg::OVP_DGL_MS - 1) begin
				ovp_act_reg <= 1'b0;
			end
			ovp_ms_reg <= ovp_ms_reg + 32'h1;
		end
	end

	// sleep entry needs the condition for 64 us; exit is immediate
	always_ff @(posedge i_clock) begin
		if (i_rst || !i_sense.in_sleep) begin
			slp_cyc_reg <= 32'h0;
			sleep_reg   <= 1'b0;
		end else if (slp_cyc_reg == lics_pkg::SLEEP_DGL_CYC - 1) begin
			sleep_reg <= 1'b1;
		end else begin
			slp_cyc_reg <= slp_cyc_reg + 32'h1;
		end
	end

	// ship exit qualifier: input present 10 ms continuously
	always_ff @(posedge i_clock) begin
		if (i_rst || !i_ship || !i_sense.in_present) begin
			wake_ms_reg <= 32'h0;
			wake_reg    <= 1'b0;
		end else if (tick) begin
			if (wake_ms_reg == lics_pkg::WAKE_MS - 1) begin
				wake_reg <= 1'b1;
			end else begin
				wake_ms_reg <= wake_ms_reg + 32'h1;
			end
		end
	end

	// overcurrent hold 250 ms; any trip rearms it and restarts the 2 s retry count
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ocp_hold_reg <= 1'b0;
			ocp_ms_reg   <= 32'h0;
			retry_ms_reg <= 32'h0;
		end else if (i_sense.bat_ocp) begin
			ocp_hold_reg <= 1'b1;
			ocp_ms_reg   <= 32'h0;
			retry_ms_reg <= 32'h0;
		end else if (tick) begin
			if (ocp_hold_reg) begin
				ocp_ms_reg <= ocp_ms_reg + 32'h1;
				if (ocp_ms_reg == lics_pkg::OCP_REC_MS - 1) begin
					ocp_hold_reg <= 1'b0;
				end
			end
			if (retry_ms_reg != lics_pkg::OCP_RETRY_MS) begin
				retry_ms_reg <= retry_ms_reg + 32'h1;
			end
		end
	end

	// undervoltage disconnect after 60 us below the level
	always_ff @(posedge i_clock) begin
		if (i_rst || !i_sense.bat_uvlo) begin
			uv_cyc_reg <= 32'h0;
			uv_off_reg <= 1'b0;
		end else if (uv_cyc_reg == lics_pkg::UVLO_DGL_CYC - 1) begin
			uv_off_reg <= 1'b1;
		end else begin
			uv_cyc_reg <= uv_cyc_reg + 32'h1;
		end
	end

	// temp bias: always on with input, 4/196 ms duty on battery only
	always_ff @(posedge i_clock) begin
		if (i_rst || i_sense.in_present) begin
			ts_ms_reg   <= 32'h0;
			ts_bias_reg <= 1'b1;
		end else if (tick) begin
			if (ts_bias_reg && ts_ms_reg == lics_pkg::TS_ON_MS - 1) begin
				ts_bias_reg <= 1'b0;
				ts_ms_reg   <= 32'h0;
			end else if (!ts_bias_reg && ts_ms_reg == lics_pkg::TS_OFF_MS - 1) begin
				ts_bias_reg <= 1'b1;
				ts_ms_reg   <= 32'h0;
			end else begin
				ts_ms_reg <= ts_ms_reg + 32'h1;
			end
		end
	end

	// watchdog: sel 0 off, 1 is 40 s, 2 and 3 are 160 s; pulse on expiry
	always_ff @(posedge i_clock) begin
		if (i_rst || kick || wdog_sel_reg == 2'h0 || wd_rst_reg) begin
			wd_ms_reg  <= 32'h0;
			wd_rst_reg <= 1'b0;
		end else if (tick) begin
			if (wd_ms_reg == ((wdog_sel_reg == 2'h1) ? lics_pkg::WDOG_SHORT_MS : lics_pkg::WDOG_LONG_MS) - 1) begin
				wd_rst_reg <= 1'b1;
			end
			wd_ms_reg <= wd_ms_reg + 32'h1;
		end
	end

	// bus idle 500 ms gives a one-cycle interface reset pulse
	always_ff @(posedge i_clock) begin
		if (i_rst || i_bus_activity || bus_rst_reg) begin
			idle_ms_reg <= 32'h0;
			bus_rst_reg <= 1'b0;
		end else if (tick) begin
			if (idle_ms_reg == lics_pkg::BUS_IDLE_MS - 1) begin
				bus_rst_reg <= 1'b1;
			end
			idle_ms_reg <= idle_ms_reg + 32'h1;
		end
	end

	// control outputs, registered
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_ctl <= '0;
		end else begin
			o_ctl.battery_switch <= (state_reg == lics_pkg::ST_TRICKLE || state_reg == lics_pkg::ST_PRECHG
				|| state_reg == lics_pkg::ST_FAST) && !ocp_hold_reg && !uv_off_reg;
			// supplement ignores the inhibit bit on purpose
			o_ctl.supplement <= i_sense.sys_need && !uv_off_reg && !ocp_hold_reg;
			o_ctl.current_sel <= (state_reg == lics_pkg::ST_TRICKLE) ? 2'h1
				: (state_reg == lics_pkg::ST_PRECHG) ? 2'h2
				: (state_reg == lics_pkg::ST_FAST) ? 2'h3 : 2'h0;
			o_ctl.reduce_cur <= i_sense.ts_fault || i_sense.vin_limit
				|| i_sense.therm_reg || i_sense.pp_limit;
			o_ctl.term_sel   <= term_reg;
			o_ctl.ts_bias    <= ts_bias_reg;
			o_ctl.sleep      <= sleep_reg;
			o_ctl.in_ovp_act <= ovp_act_reg;
			o_ctl.wake_ok    <= wake_reg;
			o_ctl.ocp_hold   <= ocp_hold_reg;
		end
	end

	assign o_charge_done = done_reg;
	assign o_timer_fault = fault_reg;
	assign o_wdog_reset  = wd_rst_reg;
	assign o_bus_reset   = bus_rst_reg;

endmodule
`default_nettype wire

// file: lics_sequencer_asserts.sv
/*
 * lics_sequencer_asserts: port checks for the charge sequencer.
 * Assumes a bind onto lics_sequencer, one clock and a sync active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module lics_sequencer_asserts #(
	parameter int unsigned MS_CYC = lics_pkg::MS_CYCLES
) (
	input wire logic                  i_clock,
	input wire logic                  i_rst,
	input wire lics_pkg::lics_sense_t i_sense,
	input wire logic                  i_bus_activity,
	input wire logic                  i_wr,
	input wire logic                  i_rd,
	input wire logic [31:0]           o_rdata,
	input wire lics_pkg::lics_ctl_t   o_ctl,
	input wire logic                  o_charge_done,
	input wire logic                  o_timer_fault,
	input wire logic                  o_bus_reset
);
	int unsigned ovp_cnt;
	int unsigned idle_cnt;
	logic        term_ok;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	// pure cv taper with no limiting loop pulling current down
	assign term_ok = i_sense.at_term && i_sense.cv_loop && !(i_sense.vin_limit || i_sense.pp_limit || i_sense.therm_reg);

	// cycles since overvoltage cleared; parked at max until one is seen
	always_ff @(posedge i_clock) begin
		if (i_rst || i_sense.in_ovp)
			ovp_cnt <= i_rst ? 32'hFFFF_FFFF : 32'h0;
		else if (ovp_cnt != 32'hFFFF_FFFF)
			ovp_cnt <= ovp_cnt + 1;
	end

	// quiet bus cycles; any access counts as traffic to stay on the safe side
	always_ff @(posedge i_clock) begin
		if (i_rst || i_bus_activity || i_wr || i_rd || o_bus_reset)
			idle_cnt <= 0;
		else
			idle_cnt <= idle_cnt + 1;
	end

	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside read slot");
	valid_start_a: assert property (o_ctl.battery_switch |-> $past(i_sense.in_valid, 2))
		else $error("battery switch on without valid input");
	done_open_a: assert property (o_charge_done && $past(o_charge_done) |-> !o_ctl.battery_switch)
		else $error("battery switch on after termination");
	done_cause_a: assert property ($rose(o_charge_done) |-> $past(term_ok) || $past(term_ok, 2))
		else $error("charge done without clean cv termination");
	done_term_a: assert property ($rose(o_charge_done) |-> o_ctl.term_sel != 2'h0)
		else $error("charge done while termination disabled");
	fault_open_a: assert property (o_timer_fault && $past(o_timer_fault) |-> !o_ctl.battery_switch)
		else $error("battery switch on during timer fault");
	ovp_hold_a: assert property (ovp_cnt >= 3 && ovp_cnt < 29 * MS_CYC |-> o_ctl.in_ovp_act)
		else $error("overvoltage hold released early");
	ovp_free_a: assert property (ovp_cnt == 31 * MS_CYC + 4 |-> !o_ctl.in_ovp_act)
		else $error("overvoltage hold released late");
	bus_idle_a: assert property (o_bus_reset |-> idle_cnt >= 499 * MS_CYC && idle_cnt <= 501 * MS_CYC + 4)
		else $error("bus reset at wrong idle time");
	ts_duty_a: assert property ($rose(o_ctl.ts_bias) && !i_sense.in_present |=> o_ctl.ts_bias [*2])
		else $error("temp bias on period too short");
endmodule
`default_nettype wire

// file: lics_battery_model.sv
/*
 * lics_battery_model: behavioural cell and comparators beside the sequencer.
 * Assumes the bench drives input-side levels and loads a start voltage.
 */
`timescale 1ns/1ps
`default_nettype none
module lics_battery_model (
	input wire logic                  i_clock,
	input wire lics_pkg::lics_ctl_t   i_ctl,
	input wire lics_pkg::lics_sense_t i_env,
	input wire logic                  i_load,
	input wire logic [12:0]           i_load_mv,
	input wire logic                  i_freeze,
	output var lics_pkg::lics_sense_t o_sense
);
	logic [12:0] bat_mv;

	// cell climbs by the current code; freeze models a cell that never charges
	always_ff @(posedge i_clock) begin
		if (i_load)
			bat_mv <= i_load_mv;
		else if (i_ctl.battery_switch && !i_freeze && bat_mv < 13'h1068)
			bat_mv <= bat_mv + 13'(i_ctl.current_sel);
	end

	// comparators; current reaches the threshold just under full voltage
	always_comb begin
		o_sense = i_env;
		o_sense.bat_short = bat_mv < 13'h0708;
		o_sense.bat_low = bat_mv < 13'h0BB8;
		o_sense.bat_uvlo = bat_mv < 13'h09C4;
		o_sense.bat_rech = bat_mv < 13'h1004;
		o_sense.cv_loop = bat_mv >= 13'h1036;
		o_sense.at_term = bat_mv >= 13'h1063;
	end
endmodule
`default_nettype wire

// file: lics_sequencer_tb.sv
/*
 * lics_sequencer_tb: directed bench for the charge sequencer with a cell model.
 * Assumes MS_CYC of 1, so every millisecond timer counts single cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module lics_sequencer_tb;
	localparam int unsigned MSC = 1;
	logic                  clk;
	logic                  rst = 1'b1;
	logic                  bus_act = 1'b1;
	logic                  wr = 1'b0;
	logic                  rd = 1'b0;
	logic                  load = 1'b1;
	logic                  freeze = 1'b0;
	logic                  ship = 1'b0;
	logic [7:0]            addr = 8'h00;
	logic [31:0]           wdata = 32'h0;
	logic [31:0]           rdata;
	logic [31:0]           v;
	logic [12:0]           load_mv = 13'h03E8;
	lics_pkg::lics_sense_t env = '0;
	lics_pkg::lics_sense_t sense;
	lics_pkg::lics_ctl_t   ctl;
	logic                  done;
	logic                  fault;
	logic                  wdog;
	logic                  busr;
	int                    err_count = 0;
	int                    total_checks = 0;
	int                    n;

	lics_sequencer #(.MS_CYC(MSC)) lics_sequencer_inst (
		.i_clock(clk), .i_rst(rst), .i_sense(sense), .i_ship(ship),
		.i_bus_activity(bus_act), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_ctl(ctl), .o_charge_done(done),
		.o_timer_fault(fault), .o_wdog_reset(wdog), .o_bus_reset(busr));
	lics_battery_model lics_battery_model_inst (
		.i_clock(clk), .i_ctl(ctl), .i_env(env), .i_load(load),
		.i_load_mv(load_mv), .i_freeze(freeze), .o_sense(sense));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic in_range(input int lo, input int hi);
		check(32'(n >= lo && n <= hi), 32'h1);
	endtask

	task automatic skip(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	// bus cycles; a gap cycle after each keeps strobes from double assignment
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic set_bat(input logic [12:0] mv);
		@(posedge clk);
		load <= 1'b1;
		load_mv <= mv;
		@(posedge clk);
		load <= 1'b0;
	endtask

	function automatic logic [31:0] probe(input int w);
		case (w)
			0: probe = 32'(ctl.current_sel);
			1: probe = 32'(done);
			2: probe = 32'(fault);
			3: probe = 32'(busr);
			4: probe = 32'(ctl.in_ovp_act);
			5: probe = 32'(ctl.battery_switch);
			6: probe = 32'(ctl.ts_bias);
			default: probe = 32'(wdog);
		endcase
	endfunction

	// bounded wait; n holds the cycles it took
	task automatic wait_on(input int w, input logic [31:0] val, input int lim);
		#1;
		for (n = 0; n < lim && probe(w) !== val; n++)
			skip(1);
		if (probe(w) !== val) begin
			check(probe(w), val);
			stop_test();
		end
	endtask

	task automatic t_regs();
		rd_reg(lics_pkg::ADDR_CTRL);
		check(v, 32'h0000_0002);
		rd_reg(lics_pkg::ADDR_VREG);
		check(v, 32'h0000_1068);
		rd_reg(lics_pkg::ADDR_TIMER);
		check(v, 32'h0000_00B4);
		rd_reg(8'h20);
		check(v, 32'h0);
		wr_reg(lics_pkg::ADDR_VREG, 32'h0000_1388);
		rd_reg(lics_pkg::ADDR_VREG_EFF);
		check(v, 32'h0000_122A);
		wr_reg(lics_pkg::ADDR_VREG, 32'h0000_1068);
		rd_reg(lics_pkg::ADDR_VREG_EFF);
		check(v, 32'h0000_1068);
		wr_reg(lics_pkg::ADDR_TIMER, 32'h1);
	endtask

	// short cell through every phase to termination, then a recharge
	task automatic t_charge();
		@(posedge clk);
		env.in_valid <= 1'b1;
		wait_on(0, 32'h1, 20);
		check(32'(ctl.battery_switch), 32'h1);
		wait_on(0, 32'h2, 2000);
		wait_on(0, 32'h3, 2000);
		wait_on(1, 32'h1, 2000);
		rd_reg(lics_pkg::ADDR_STATUS);
		check(v & 32'h17, 32'h14);
		check(32'(ctl.battery_switch), 32'h0);
		set_bat(13'h0FA0);
		wait_on(1, 32'h0, 20);
		wait_on(0, 32'h3, 20);
		wait_on(1, 32'h1, 500);
	endtask

	// limiting loop blocks termination; every termination code
	task automatic t_term();
		@(posedge clk);
		env.vin_limit <= 1'b1;
		set_bat(13'h0FA0);
		wait_on(0, 32'h3, 20);
		skip(4);
		check(32'(ctl.reduce_cur), 32'h1);
		skip(300);
		check(32'(done), 32'h0);
		@(posedge clk);
		env.vin_limit <= 1'b0;
		wait_on(1, 32'h1, 20);
		for (int t = 3; t >= 0; t--) begin
			wr_reg(lics_pkg::ADDR_CTRL, 32'(t) << 1);
			skip(3);
			check(32'(ctl.term_sel), 32'(t));
		end
		set_bat(13'h0FA0);
		wait_on(0, 32'h3, 20);
		skip(300);
		check(32'(done), 32'h0);
		wr_reg(lics_pkg::ADDR_CTRL, 32'h2);
		wait_on(1, 32'h1, 20);
	endtask

	task automatic t_inhibit();
		@(posedge clk);
		freeze <= 1'b1;
		env.sys_need <= 1'b1;
		set_bat(13'h0FA0);
		wait_on(5, 32'h1, 20);
		wr_reg(lics_pkg::ADDR_CTRL, 32'h3);
		wait_on(5, 32'h0, 20);
		rd_reg(lics_pkg::ADDR_STATUS);
		check(v & 32'h7, 32'h6);
		check(32'(ctl.supplement), 32'h1);
		@(posedge clk);
		freeze <= 1'b0;
		env.sys_need <= 1'b0;
		wr_reg(lics_pkg::ADDR_CTRL, 32'h2);
		wait_on(1, 32'h1, 500);
	endtask

	// deglitch, idle and duty timers measured in cycles
	task automatic t_timers();
		@(posedge clk);
		env.in_ovp <= 1'b1;
		env.in_valid <= 1'b0;
		skip(10);
		check(32'(ctl.in_ovp_act), 32'h1);
		@(posedge clk);
		env.in_ovp <= 1'b0;
		env.in_valid <= 1'b1;
		wait_on(4, 32'h0, 100);
		in_range(28, 35);
		@(posedge clk);
		bus_act <= 1'b0;
		wait_on(3, 32'h1, 700);
		in_range(495, 506);
		@(posedge clk);
		bus_act <= 1'b1;
		env.in_present <= 1'b0;
		env.in_valid <= 1'b0;
		wait_on(6, 32'h0, 300);
		wait_on(6, 32'h1, 300);
		in_range(192, 200);
		wait_on(6, 32'h0, 20);
		in_range(3, 6);
		@(posedge clk);
		env.in_present <= 1'b1;
		env.in_valid <= 1'b1;
		// wake qualifier and overcurrent hold with input back
		@(posedge clk);
		ship <= 1'b1;
		env.bat_ocp <= 1'b1;
		@(posedge clk);
		env.bat_ocp <= 1'b0;
		skip(8);
		check(32'(ctl.wake_ok), 32'h0);
		skip(4);
		check(32'(ctl.wake_ok), 32'h1);
		skip(230);
		check(32'(ctl.ocp_hold), 32'h1);
		skip(20);
		check(32'(ctl.ocp_hold), 32'h0);
	endtask

	// stuck cell overruns the quarter budget; new cycle clears the flag
	task automatic t_fault();
		@(posedge clk);
		freeze <= 1'b1;
		set_bat(13'h0AF0);
		wait_on(0, 32'h2, 50);
		wait_on(2, 32'h1, 16000);
		in_range(14980, 15020);
		skip(3);
		check(32'(ctl.battery_switch), 32'h0);
		rd_reg(lics_pkg::ADDR_STATUS);
		check(v & 32'h27, 32'h25);
		@(posedge clk);
		freeze <= 1'b0;
		env.in_valid <= 1'b0;
		repeat (3) @(posedge clk);
		env.in_valid <= 1'b1;
		wait_on(2, 32'h0, 20);
	endtask

	task automatic t_wdog();
		wr_reg(lics_pkg::ADDR_CTRL, 32'h2A);
		wait_on(7, 32'h1, 41000);
		in_range(39980, 40020);
		wr_reg(lics_pkg::ADDR_CTRL, 32'h2);
	endtask

	initial begin
		env.in_present = 1'b1;
		env.ts_ok = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		load <= 1'b0;
		t_regs();
		t_charge();
		t_term();
		t_inhibit();
		t_timers();
		t_fault();
		t_wdog();
		stop_test();
	end
endmodule

bind lics_sequencer lics_sequencer_asserts #(.MS_CYC(MS_CYC)) lics_sequencer_asserts_inst (
	.i_clock(i_clock), .i_rst(i_rst), .i_sense(i_sense), .i_bus_activity(i_bus_activity),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ctl(o_ctl), .o_charge_done(o_charge_done),
	.o_timer_fault(o_timer_fault), .o_bus_reset(o_bus_reset));
`default_nettype wire
